// File: core/ccdrs_host.sv
// Processor-side party: frequency source, clock sync, enables and bus ready
`timescale 1ns/1ps
module ccdrs_host #(
  parameter int EFI_HALF   = ccdrs_pkg::EFI_HALF_CYCLES,
  parameter int SYNC_WIDTH = ccdrs_pkg::CLOCK_SYNC_IN_EFI_PERIODS
) (
  // Pins towards the clock generator
  ccdrs_if.host     link,
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // User controls
  input  wire logic use_ext,
  input  wire logic single_sync,
  input  wire logic reset_req,
  input  wire logic sync_req,
  input  wire logic port_sel,
  input  wire logic cycle_active,
  input  wire logic cycle_done,
  // User status
  output logic      sync_busy
);

  localparam int EW = (EFI_HALF > 1) ? $clog2(EFI_HALF) : 1;
  localparam int SW = $clog2(SYNC_WIDTH + 1);

  typedef enum logic [1:0] {
    SY_IDLE = 2'h0,
    SY_ARM  = 2'h1,
    SY_HOLD = 2'h2
  } ccdrs_sync_t;

  // ==========================================================
  // External frequency source
  // ==========================================================
  logic [EW-1:0] efi_cnt_q;
  logic          efi_q;
  logic          efi_wrap;
  logic          efi_rise;

  assign efi_wrap = (efi_cnt_q == EW'(EFI_HALF - 1));
  assign efi_rise = efi_wrap & ~efi_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      efi_cnt_q <= '0;
    else if (efi_wrap)
      efi_cnt_q <= '0;
    else
      efi_cnt_q <= efi_cnt_q + EW'(1);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      efi_q <= 1'h0;
    else if (efi_wrap)
      efi_q <= ~efi_q;
  end

  // ==========================================================
  // Clock sync pulse
  // ==========================================================
  ccdrs_sync_t   sy_q;
  logic [SW-1:0] sy_cnt_q;
  logic          clock_sync_in_q;

  // Sync rises and falls with a source rising edge; on crystal it is forced low at once
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sy_q     <= SY_IDLE;
      sy_cnt_q <= '0;
      clock_sync_in_q  <= 1'h0;
    end
    else if (!use_ext)
    begin
      sy_q    <= SY_IDLE;
      clock_sync_in_q <= 1'h0;
    end
    else
    begin
      case (sy_q)
        SY_IDLE:
          if (sync_req)
            sy_q <= SY_ARM;
        SY_ARM:
          if (efi_rise)
          begin
            sy_q     <= SY_HOLD;
            sy_cnt_q <= '0;
            clock_sync_in_q  <= 1'h1;
          end
        SY_HOLD:
          if (efi_rise)
          begin
            if (sy_cnt_q == SW'(SYNC_WIDTH - 1))
            begin
              sy_q    <= SY_IDLE;
              clock_sync_in_q <= 1'h0;
            end
            sy_cnt_q <= sy_cnt_q + SW'(1);
          end
        default:
          sy_q <= SY_IDLE;
      endcase
    end
  end

  assign sync_busy = (sy_q != SY_IDLE);

  // ==========================================================
  // Enables, bus ready and static pins
  // ==========================================================
  logic addr_enable_1_n_n_q;
  logic addr_enable_2_n_n_q;
  logic rdy_q;
  logic sel_q;
  logic mode_q;
  logic rst_n_q;

  // Only the enable of the port in use goes low
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      addr_enable_1_n_n_q <= 1'h1;
      addr_enable_2_n_n_q <= 1'h1;
      sel_q    <= ccdrs_pkg::SEL_CRYSTAL;
      mode_q   <= ccdrs_pkg::MODE_SINGLE;
      rst_n_q  <= 1'h0;
    end
    else
    begin
      addr_enable_1_n_n_q <= ~(cycle_active & ~port_sel);
      addr_enable_2_n_n_q <= ~(cycle_active & port_sel);
      sel_q    <= use_ext;
      mode_q   <= single_sync;
      rst_n_q  <= ~reset_req;
    end
  end

  // Completion sets ready; a completion in the clearing cycle still wins
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rdy_q <= 1'h0;
    else if (cycle_done)
      rdy_q <= 1'h1;
    else if (!cycle_active)
      rdy_q <= 1'h0;
  end

  assign link.ext_freq_in       = efi_q;
  assign link.clock_sync_in     = clock_sync_in_q;
  assign link.freq_select       = sel_q;
  assign link.ready_sync_mode_n = mode_q;
  assign link.reset_request_n   = rst_n_q;
  assign link.addr_enable_1_n   = addr_enable_1_n_n_q;
  assign link.addr_enable_2_n   = addr_enable_2_n_n_q;
  assign link.bus_ready_1       = rdy_q & ~port_sel;
  assign link.bus_ready_2       = rdy_q & port_sel;

endmodule : ccdrs_host

// File: core/ccdrs_pkg.sv
// Shared constants for the processor clock divider and ready synchroniser
package ccdrs_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int REF_CLK_HZ        = 25_000_000;
  localparam int OSC_HALF_CYCLES   = 1;  // Modelled crystal: half period in ref_clk cycles
  localparam int EFI_HALF_CYCLES   = 2;  // Host frequency source: half period in ref_clk cycles
  localparam int CLOCK_SYNC_IN_EFI_PERIODS = 2;  // Least sync pulse, in source periods

  // ==========================================================
  // Divide-by-three phases
  // ==========================================================
  typedef enum logic [1:0] {
    PH_LOW0 = 2'h0,
    PH_LOW1 = 2'h1,
    PH_HIGH = 2'h2
  } ccdrs_phase_t;

  localparam ccdrs_phase_t PHASE_RESET = PH_HIGH;

  // ==========================================================
  // Pin levels and reset values
  // ==========================================================
  localparam logic SEL_CRYSTAL   = 1'h0;
  localparam logic SEL_EXTERNAL  = 1'h1;
  localparam logic MODE_DOUBLE   = 1'h0;
  localparam logic MODE_SINGLE   = 1'h1;
  localparam logic CPU_RESET_RST = 1'h1;
  localparam logic PCLK_RST      = 1'h0;

endpackage : ccdrs_pkg

// File: core/ccdrs_if.sv
// Pin bundle between the clock generator and the processor-side party
`timescale 1ns/1ps
interface ccdrs_if;
  // Source selection and frequency input
  logic freq_select;
  logic ext_freq_in;
  logic clock_sync_in;
  // Bus ready qualification
  logic addr_enable_1_n;
  logic addr_enable_2_n;
  logic bus_ready_1;
  logic bus_ready_2;
  logic ready_sync_mode_n;
  // Reset request
  logic reset_request_n;
  // Generated outputs
  logic cpu_clk;
  logic periph_clk;
  logic cpu_ready;
  logic cpu_reset;
  logic osc_tap_out;

  modport dev (
    input  freq_select, ext_freq_in, clock_sync_in,
    input  addr_enable_1_n, addr_enable_2_n, bus_ready_1, bus_ready_2,
    input  ready_sync_mode_n, reset_request_n,
    output cpu_clk, periph_clk, cpu_ready, cpu_reset, osc_tap_out
  );

  modport host (
    output freq_select, ext_freq_in, clock_sync_in,
    output addr_enable_1_n, addr_enable_2_n, bus_ready_1, bus_ready_2,
    output ready_sync_mode_n, reset_request_n,
    input  cpu_clk, periph_clk, cpu_ready, cpu_reset, osc_tap_out
  );
endinterface : ccdrs_if

// File: core/ccdrs_ready_sync.sv
// Ready synchroniser with one or two stages keyed to processor clock edges
`timescale 1ns/1ps
module ccdrs_ready_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Processor clock edge strobes
  input  wire logic rise_en,
  input  wire logic fall_en,
  // Mode and qualified ready
  input  wire logic mode_n,
  input  wire logic ready_in,
  // Synchronised ready
  output logic      ready_q
);

  // ==========================================================
  // First stage
  // ==========================================================
  logic stage1_q;

  // Taken on the processor clock rise; only the second stage reads it
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      stage1_q <= 1'h0;
    else if (rise_en)
      stage1_q <= ready_in;
  end

  // ==========================================================
  // Output stage
  // ==========================================================
  // Output changes on the falling edge, so the processor sees it held
  // across its whole sampling window
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ready_q <= 1'h0;
    else if (fall_en)
    begin
      if (mode_n == ccdrs_pkg::MODE_DOUBLE)
        ready_q <= stage1_q;
      else
        ready_q <= ready_in;
    end
  end

endmodule : ccdrs_ready_sync

// File: core/ccdrs_device.sv
// Processor clock generator: divide by three, peripheral clock, ready and reset
//
// Contract
// - Processor clock is source over three, 33%
// - Sync high: counter held, clock forced high
// - Host aligns frequency input to sync
// - Host keeps sync low on crystal
// - Peripheral clock: half rate, 50% duty
// - Each ready gated by its enable
// - Single master drives only one enable
// - Bus device raises ready on completion
// - Ready output synced, in phase, hold kept
// - Two source periods low, one high
// - Reset request synced and inverted
// - Select low crystal, high external input
// - Mode low two stages, high one
`timescale 1ns/1ps
module ccdrs_device #(
  parameter int OSC_HALF = ccdrs_pkg::OSC_HALF_CYCLES
) (
  // Pins towards the processor system
  ccdrs_if.dev      link,
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Observation strobes
  output logic      cpu_rise,
  output logic      cpu_fall,
  output logic      src_tick
);

  localparam int OSC_W = (OSC_HALF > 1) ? $clog2(OSC_HALF) : 1;

  // ==========================================================
  // Modelled crystal oscillator
  // ==========================================================
  logic [OSC_W-1:0] osc_cnt_q;
  logic             osc_phase_q;
  logic             osc_wrap;
  logic             osc_tick;

  assign osc_wrap = (osc_cnt_q == OSC_W'(OSC_HALF - 1));
  assign osc_tick = osc_wrap & ~osc_phase_q;

  // Half-period counter; the crystal runs regardless of the selector
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      osc_cnt_q <= '0;
    else if (osc_wrap)
      osc_cnt_q <= '0;
    else
      osc_cnt_q <= osc_cnt_q + OSC_W'(1);
  end

  // Square wave shown on the tap output
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      osc_phase_q <= 1'h0;
    else if (osc_wrap)
      osc_phase_q <= ~osc_phase_q;
  end

  assign link.osc_tap_out = osc_phase_q;

  // ==========================================================
  // External frequency input edge
  // ==========================================================
  logic efi_prev_q;
  logic efi_tick;

  // Pin is taken as synchronous, so one register finds the rising edge
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      efi_prev_q <= 1'h0;
    else
      efi_prev_q <= link.ext_freq_in;
  end

  assign efi_tick = link.ext_freq_in & ~efi_prev_q;

  // ==========================================================
  // Source selection
  // ==========================================================
  // Both sources are enables of ref_clk, so switching cannot glitch
  always_comb
  begin
    if (link.freq_select == ccdrs_pkg::SEL_EXTERNAL)
      src_tick = efi_tick;
    else
      src_tick = osc_tick;
  end

  // ==========================================================
  // Divide-by-three counter
  // ==========================================================
  ccdrs_pkg::ccdrs_phase_t phase_q;
  ccdrs_pkg::ccdrs_phase_t phase_d;

  // Low, low, high: one third high per processor cycle
  always_comb
  begin
    phase_d = phase_q;
    if (link.clock_sync_in)
      phase_d = ccdrs_pkg::PH_HIGH;
    else if (src_tick)
    begin
      case (phase_q)
        ccdrs_pkg::PH_HIGH: phase_d = ccdrs_pkg::PH_LOW0;
        ccdrs_pkg::PH_LOW0: phase_d = ccdrs_pkg::PH_LOW1;
        ccdrs_pkg::PH_LOW1: phase_d = ccdrs_pkg::PH_HIGH;
        default:            phase_d = ccdrs_pkg::PH_LOW0;
      endcase
    end
  end

  // Holding the high phase during sync makes the release start a low phase
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase_q <= ccdrs_pkg::PHASE_RESET;
    else
      phase_q <= phase_d;
  end

  // ==========================================================
  // Processor clock and edge strobes
  // ==========================================================
  logic cpu_clk_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cpu_clk_q <= 1'h1;
    else
      cpu_clk_q <= (phase_d == ccdrs_pkg::PH_HIGH);
  end

  assign link.cpu_clk = cpu_clk_q;

  // Strobes mark the cycle at whose end the clock output changes
  assign cpu_rise = ~cpu_clk_q & (phase_d == ccdrs_pkg::PH_HIGH);
  assign cpu_fall = cpu_clk_q & (phase_d != ccdrs_pkg::PH_HIGH);

  // ==========================================================
  // Peripheral clock
  // ==========================================================
  logic pclk_q;

  // One toggle per processor cycle halves the rate at even duty
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pclk_q <= ccdrs_pkg::PCLK_RST;
    else if (cpu_fall)
      pclk_q <= ~pclk_q;
  end

  assign link.periph_clk = pclk_q;

  // ==========================================================
  // Ready qualification
  // ==========================================================
  logic ready_gated_1;
  logic ready_gated_2;
  logic ready_qual;

  assign ready_gated_1 = link.bus_ready_1 & ~link.addr_enable_1_n;
  assign ready_gated_2 = link.bus_ready_2 & ~link.addr_enable_2_n;
  assign ready_qual    = ready_gated_1 | ready_gated_2;

  // ==========================================================
  // Ready synchroniser
  // ==========================================================
  logic ready_sync;

  // Falling-edge output gives the processor its hold time
  ccdrs_ready_sync u_ready_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .rise_en  (cpu_rise),
    .fall_en  (cpu_fall),
    .mode_n   (link.ready_sync_mode_n),
    .ready_in (ready_qual),
    .ready_q  (ready_sync)
  );

  assign link.cpu_ready = ready_sync;

  // ==========================================================
  // Reset synchroniser
  // ==========================================================
  logic rst_s1_q;
  logic cpu_reset_q;

  // First stage is read only by the second; both step on the falling edge
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rst_s1_q <= 1'h0;
    else if (cpu_fall)
      rst_s1_q <= link.reset_request_n;
  end

  // Output has the opposite sense of the request pin
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cpu_reset_q <= ccdrs_pkg::CPU_RESET_RST;
    else if (cpu_fall)
      cpu_reset_q <= ~rst_s1_q;
  end

  assign link.cpu_reset = cpu_reset_q;

endmodule : ccdrs_device

// File: verif/ccdrs_chk.sv
// Concurrent checks on the pins between the clock generator and the processor side
`timescale 1ns/1ps
module ccdrs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Host-driven pins
  input wire logic freq_select,
  input wire logic clock_sync_in,
  input wire logic addr_enable_1_n,
  input wire logic addr_enable_2_n,
  input wire logic bus_ready_1,
  input wire logic bus_ready_2,
  input wire logic ready_sync_mode_n,
  input wire logic reset_request_n,
  // Generated pins
  input wire logic cpu_clk,
  input wire logic periph_clk,
  input wire logic cpu_ready,
  input wire logic cpu_reset
);
  // ========================================================
  // Helpers
  // ========================================================
  logic qual;
  logic quiet;
  // Each ready only counts while its own enable is low
  assign qual  = (bus_ready_1 & ~addr_enable_1_n) | (bus_ready_2 & ~addr_enable_2_n);
  // Crystal source with no sync: the case whose two-cycle tick spacing the checks assume
  assign quiet = !clock_sync_in && !freq_select;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // The edge itself must come from a crystal tick, not one left over from
  // the external input just before a source switch
  sequence s_rise;
    $rose(cpu_clk) && quiet && $past(quiet);
  endsequence
  sequence s_fall;
    $fell(cpu_clk) && quiet && $past(quiet);
  endsequence

  // ========================================================
  // Properties
  // ========================================================
  property p_sync_high;
    clock_sync_in |=> cpu_clk;
  endproperty
  property p_high_tick;
    s_rise ##1 quiet |=> !cpu_clk;
  endproperty
  property p_low_ticks;
    s_fall ##1 quiet[*4] |-> cpu_clk && !$past(cpu_clk) && !$past(cpu_clk, 2) && !$past(cpu_clk, 3);
  endproperty
  property p_pclk_fall;
    $changed(periph_clk) == $fell(cpu_clk);
  endproperty
  property p_ready_fall;
    $changed(cpu_ready) |-> $fell(cpu_clk);
  endproperty
  property p_ready_single;
    $fell(cpu_clk) && $past(ready_sync_mode_n) |-> cpu_ready == $past(qual);
  endproperty
  property p_ready_double;
    s_rise ##1 (quiet && !ready_sync_mode_n) |=> cpu_ready == $past(qual, 3);
  endproperty
  // Previous fall six cycles back, so the first stage holds the request of then
  property p_reset_sync;
    $fell(cpu_clk) && $past(cpu_clk, 7) && !$past(cpu_clk, 6)
      |-> cpu_reset == !$past(reset_request_n, 7);
  endproperty

  a_sync_high: assert property (p_sync_high)
    else $error("clock not held high under sync");
  a_high_tick: assert property (p_high_tick)
    else $error("clock high phase longer than one tick");
  a_low_ticks: assert property (p_low_ticks)
    else $error("clock low phase not two ticks");
  a_pclk_fall: assert property (p_pclk_fall)
    else $error("peripheral clock off the falling edge");
  a_ready_fall: assert property (p_ready_fall)
    else $error("ready moved off a falling edge");
  a_ready_single: assert property (p_ready_single)
    else $error("single stage ready wrong");
  a_ready_double: assert property (p_ready_double)
    else $error("double stage ready wrong");
  a_reset_sync: assert property (p_reset_sync)
    else $error("reset output not synced and inverted");
endmodule : ccdrs_chk

// File: verif/tb_cpu_clock_divider_ready_sync.sv
// Testbench joining both ends of the clock generator through the pin bundle
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_cpu_clock_divider_ready_sync;
  logic        ref_clk;
  logic        reset;
  logic        use_ext;
  logic        single_sync;
  logic        reset_req;
  logic        sync_req;
  logic        port_sel;
  logic        cycle_active;
  logic        cycle_done;
  logic [31:0] rnd;
  logic        c_prev, q_prev, m_prev, r_prev, m_s1, m_rdy, m_rs, m_rst, m_pclk;
  int          miscompares;
  int          checks_done;
  int          hi, lo, n;
  wire         qual;

  ccdrs_if link ();
  assign qual = (link.bus_ready_1 & ~link.addr_enable_1_n) |
                (link.bus_ready_2 & ~link.addr_enable_2_n);

  ccdrs_device u_ccdrs_device (.link(link), .ref_clk(ref_clk), .reset(reset),
    .cpu_rise(), .cpu_fall(), .src_tick());
  ccdrs_host u_ccdrs_host (.link(link), .ref_clk(ref_clk), .reset(reset), .use_ext(use_ext),
    .single_sync(single_sync), .reset_req(reset_req), .sync_req(sync_req),
    .port_sel(port_sel), .cycle_active(cycle_active), .cycle_done(cycle_done), .sync_busy());
  ccdrs_chk u_ccdrs_chk (.ref_clk(ref_clk), .reset(reset), .freq_select(link.freq_select),
    .clock_sync_in(link.clock_sync_in), .addr_enable_1_n(link.addr_enable_1_n),
    .addr_enable_2_n(link.addr_enable_2_n), .bus_ready_1(link.bus_ready_1),
    .bus_ready_2(link.bus_ready_2), .ready_sync_mode_n(link.ready_sync_mode_n),
    .reset_request_n(link.reset_request_n), .cpu_clk(link.cpu_clk),
    .periph_clk(link.periph_clk), .cpu_ready(link.cpu_ready), .cpu_reset(link.cpu_reset));

  // ========================================================
  // Helpers
  // ========================================================
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Sample a little after the edge so its updates have landed
  task step;
    @(posedge ref_clk);
    #1;
  endtask : step
  // Length in cycles of one whole high phase and the low phase after it
  task measure(output int h, output int l);
    for (n = 0; n < 50 && link.cpu_clk !== 1'b0; n++) step;
    for (n = 0; n < 50 && link.cpu_clk !== 1'b1; n++) step;
    for (h = 0; h < 50 && link.cpu_clk === 1'b1; h++) step;
    for (l = 0; l < 50 && link.cpu_clk === 1'b0; l++) step;
  endtask : measure
  task test_done;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done;
  end

  // ========================================================
  // Model: ready stages, reset sync and peripheral clock on clock edges
  // ========================================================
  always @(negedge ref_clk)
  begin
    if (reset)
    begin
      // Clock high, single-stage mode, request low, reset output high, PCLK low
      {c_prev, q_prev, m_prev, r_prev, m_s1, m_rdy, m_rs, m_rst, m_pclk} = 9'h142;
    end
    else
    begin
      if (link.cpu_clk && !c_prev) m_s1 = q_prev;
      if (!link.cpu_clk && c_prev)
      begin
        m_rdy  = m_prev ? q_prev : m_s1;
        m_rst  = !m_rs;
        m_rs   = r_prev;
        m_pclk = !m_pclk;
      end
      `CHK("cpu_ready", m_rdy, link.cpu_ready)
      `CHK("cpu_reset", m_rst, link.cpu_reset)
      `CHK("periph_clk", m_pclk, link.periph_clk)
      c_prev = link.cpu_clk;
      q_prev = qual;
      m_prev = link.ready_sync_mode_n;
      r_prev = link.reset_request_n;
    end
  end

  // ========================================================
  // Scenarios
  // ========================================================
  initial
  begin
    {reset, use_ext, single_sync, reset_req, sync_req} = 5'h10;
    {port_sel, cycle_active, cycle_done, miscompares, checks_done} = '0;
    rnd = 32'h86ED;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    // Crystal source: one tick high, two low
    measure(hi, lo);
    `CHK("crystal high", 2 * ccdrs_pkg::OSC_HALF_CYCLES, hi)
    `CHK("crystal low", 4 * ccdrs_pkg::OSC_HALF_CYCLES, lo)
    // Crystal tap: the high level lasts one half period of the modelled crystal
    for (n = 0; n < 50 && link.osc_tap_out !== 1'b0; n++) step;
    for (n = 0; n < 50 && link.osc_tap_out !== 1'b1; n++) step;
    for (n = 0; n < 50 && link.osc_tap_out === 1'b1; n++) step;
    `CHK("osc tap half", ccdrs_pkg::OSC_HALF_CYCLES, n)
    // External source selected
    @(posedge ref_clk) use_ext <= 1'b1;
    repeat (30) step;
    measure(hi, lo);
    `CHK("external high", 2 * ccdrs_pkg::EFI_HALF_CYCLES, hi)
    `CHK("external low", 4 * ccdrs_pkg::EFI_HALF_CYCLES, lo)
    // Sync pulse holds the clock high, then a full low phase follows
    @(posedge ref_clk) sync_req <= 1'b1;
    @(posedge ref_clk) sync_req <= 1'b0;
    for (n = 0; n < 20 && link.clock_sync_in !== 1'b1; n++) step;
    for (n = 0; n < 40 && link.clock_sync_in === 1'b1; n++)
    begin
      step;
      `CHK("held clock", 1'b1, link.cpu_clk)
    end
    `CHK("sync width", 4 * ccdrs_pkg::EFI_HALF_CYCLES, n)
    for (n = 0; n < 20 && link.cpu_clk === 1'b1; n++) step;
    for (n = 0; n < 40 && link.cpu_clk === 1'b0; n++) step;
    `CHK("low after sync", 4 * ccdrs_pkg::EFI_HALF_CYCLES, n)
    // Bus cycles on both ports, both modes, both sources, random completion
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      use_ext      <= ~k[2];
      single_sync  <= k[0];
      port_sel     <= k[1];
      cycle_active <= 1'b1;
      repeat (rnd[2:0] + 1) @(posedge ref_clk);
      cycle_done <= 1'b1;
      @(posedge ref_clk) cycle_done <= 1'b0;
      for (n = 0; n < 60 && link.cpu_ready !== 1'b1; n++) step;
      `CHK("ready seen", 1'b1, link.cpu_ready)
      `CHK("idle enable", 1'b1, k[1] ? link.addr_enable_1_n : link.addr_enable_2_n)
      `CHK("sync on crystal", 1'b0, k[2] ? link.clock_sync_in : 1'b0)
      @(posedge ref_clk) cycle_active <= 1'b0;
      for (n = 0; n < 60 && link.cpu_ready !== 1'b0; n++) step;
    end
    // Reset request asserted and withdrawn
    @(posedge ref_clk) reset_req <= 1'b1;
    repeat (40) step;
    `CHK("reset raised", 1'b1, link.cpu_reset)
    @(posedge ref_clk) reset_req <= 1'b0;
    repeat (40) step;
    `CHK("reset dropped", 1'b0, link.cpu_reset)
    test_done;
  end
endmodule : tb_cpu_clock_divider_ready_sync
